// ---- inc/kpw_pkg.sv ----
// constants and types shared by the keypad line wakeup configuration block
`default_nettype none
package kpw_pkg;
  localparam int unsigned KPW_LINES   = 8;
  localparam int unsigned KPW_ADDR_W  = 8;
  localparam int unsigned KPW_DATA_W  = 8;

  // register offsets
  localparam logic [7:0] KPW_OFF_LEVEL_SELECT = 8'h9C;
  localparam logic [7:0] KPW_OFF_LINE_ENABLE  = 8'h9D;
  localparam logic [7:0] KPW_OFF_EVENT_FLAGS  = 8'h9E;
  localparam logic [7:0] KPW_OFF_FLAG_CLEAR   = 8'h9F;

  // reset values
  localparam logic [7:0] KPW_RST_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] KPW_RST_LINE_ENABLE  = 8'h00;
  localparam logic [7:0] KPW_RST_EVENT_FLAGS  = 8'h00;
  localparam logic [7:0] KPW_RST_PINS         = 8'h00;
  localparam logic [7:0] KPW_READ_ZERO        = 8'h00;

  typedef struct packed {
    logic [KPW_ADDR_W-1:0] addr;
    logic [KPW_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } kpw_bus_req_t;

  // per line: set where the pin shows its selected level (0 = low, 1 = high)
  function automatic logic [7:0] kpw_line_match(input logic [7:0] pins,
                                                input logic [7:0] level_sel);
    kpw_line_match = ~(pins ^ level_sel);
  endfunction
endpackage
`default_nettype wire

// ---- design/kpw_keypad_wakeup.sv ----
// keypad line event flags, level select, line enable and interrupt request
`timescale 1ns/1ps
`default_nettype none

module kpw_keypad_wakeup
  import kpw_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire kpw_bus_req_t bus_req,
  output var  logic [7:0]   rd_data,
  input  wire logic [7:0]   port_pins,
  output var  logic [7:0]   line_kbd_mode,
  output var  logic         irq
);

  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] keypad_level_select;
  logic [7:0] keypad_line_enable;
  logic [7:0] keypad_event_flags;

  // pins are asynchronous to clk; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= KPW_RST_PINS;
      pin_sync <= KPW_RST_PINS;
    end else begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
    end
  end

  // address decode
  wire        hit_level = bus_req.addr == KPW_OFF_LEVEL_SELECT;
  wire        hit_en    = bus_req.addr == KPW_OFF_LINE_ENABLE;
  wire        hit_flags = bus_req.addr == KPW_OFF_EVENT_FLAGS;
  wire        wr_level  = bus_req.wr && hit_level;
  wire        wr_en     = bus_req.wr && hit_en;
  wire        wr_clear  = bus_req.wr && (bus_req.addr == KPW_OFF_FLAG_CLEAR);

  wire [7:0] line_match = kpw_line_match(pin_sync, keypad_level_select);
  wire [7:0] clear_mask = wr_clear ? bus_req.wdata : KPW_READ_ZERO;
  // a match in the clearing cycle keeps its flag set
  wire [7:0] next_flags = (keypad_event_flags & ~clear_mask) | line_match;
  wire       next_irq   = |(keypad_event_flags & keypad_line_enable);

  // clear register and unmapped offsets read as zero (write-only clear); flag register reads back its flags
  wire [7:0] next_rd_data =
      !bus_req.rd ? KPW_READ_ZERO :
      hit_level   ? keypad_level_select :
      hit_en      ? keypad_line_enable :
      hit_flags   ? keypad_event_flags : KPW_READ_ZERO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_level_select <= KPW_RST_LEVEL_SELECT;
      keypad_line_enable  <= KPW_RST_LINE_ENABLE;
    end else begin
      if (wr_level)
        keypad_level_select <= bus_req.wdata;
      if (wr_en)
        keypad_line_enable <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_event_flags <= KPW_RST_EVENT_FLAGS;
      irq                <= 1'b0;
      rd_data            <= KPW_READ_ZERO;
    end else begin
      keypad_event_flags <= next_flags;
      irq                <= next_irq;
      rd_data            <= next_rd_data;
    end
  end

  // tells the port drivers which lines act as keypad inputs
  assign line_kbd_mode = keypad_line_enable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_match0_low;
    !keypad_level_select[0] && !pin_sync[0];
  endsequence

  sequence s_match0_high;
    keypad_level_select[0] && pin_sync[0];
  endsequence

  enable_write_a : assert property (
    wr_en |=> line_kbd_mode == $past(bus_req.wdata))
    else $error("line enable write not applied");

  plain_io_a : assert property (
    (keypad_event_flags & keypad_line_enable) == 8'h00 |=> !irq)
    else $error("interrupt raised with no enabled flag");

  irq_raise_a : assert property (
    (keypad_event_flags & keypad_line_enable) != 8'h00 |=> irq)
    else $error("enabled flag did not raise interrupt");

  low_detect_a : assert property (
    s_match0_low |=> keypad_event_flags[0])
    else $error("low level on line 0 not flagged");

  high_detect_a : assert property (
    s_match0_high |=> keypad_event_flags[0])
    else $error("high level on line 0 not flagged");

  reset_zero_a : assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |-> (keypad_level_select == 8'h00 && keypad_line_enable == 8'h00))
    else $error("config registers not zero in reset");

  flag_ungated_a : assert property (
    (!keypad_line_enable[3] && line_match[3]) |=> keypad_event_flags[3])
    else $error("flag not set while line disabled");

  flag_clear_a : assert property (
    (wr_clear && bus_req.wdata[5] && !line_match[5]) |=> !keypad_event_flags[5])
    else $error("flag clear ignored");

  read_level_a : assert property (
    (bus_req.rd && hit_level) |=> rd_data == $past(keypad_level_select) ##1
    (rd_data == 8'h00 || $past(bus_req.rd)))
    else $error("level select readback wrong");

  // level detect on the other seven lines, both polarities
  line1_low_a : assert property (
    (!keypad_level_select[1] && !pin_sync[1]) |=> keypad_event_flags[1])
    else $error("low level on line 1 not flagged");

  line1_high_a : assert property (
    (keypad_level_select[1] && pin_sync[1]) |=> keypad_event_flags[1])
    else $error("high level on line 1 not flagged");

  line2_low_a : assert property (
    (!keypad_level_select[2] && !pin_sync[2]) |=> keypad_event_flags[2])
    else $error("low level on line 2 not flagged");

  line2_high_a : assert property (
    (keypad_level_select[2] && pin_sync[2]) |=> keypad_event_flags[2])
    else $error("high level on line 2 not flagged");

  line3_low_a : assert property (
    (!keypad_level_select[3] && !pin_sync[3]) |=> keypad_event_flags[3])
    else $error("low level on line 3 not flagged");

  line3_high_a : assert property (
    (keypad_level_select[3] && pin_sync[3]) |=> keypad_event_flags[3])
    else $error("high level on line 3 not flagged");

  line4_low_a : assert property (
    (!keypad_level_select[4] && !pin_sync[4]) |=> keypad_event_flags[4])
    else $error("low level on line 4 not flagged");

  line4_high_a : assert property (
    (keypad_level_select[4] && pin_sync[4]) |=> keypad_event_flags[4])
    else $error("high level on line 4 not flagged");

  line5_low_a : assert property (
    (!keypad_level_select[5] && !pin_sync[5]) |=> keypad_event_flags[5])
    else $error("low level on line 5 not flagged");

  line5_high_a : assert property (
    (keypad_level_select[5] && pin_sync[5]) |=> keypad_event_flags[5])
    else $error("high level on line 5 not flagged");

  line6_low_a : assert property (
    (!keypad_level_select[6] && !pin_sync[6]) |=> keypad_event_flags[6])
    else $error("low level on line 6 not flagged");

  line6_high_a : assert property (
    (keypad_level_select[6] && pin_sync[6]) |=> keypad_event_flags[6])
    else $error("high level on line 6 not flagged");

  line7_low_a : assert property (
    (!keypad_level_select[7] && !pin_sync[7]) |=> keypad_event_flags[7])
    else $error("low level on line 7 not flagged");

  line7_high_a : assert property (
    (keypad_level_select[7] && pin_sync[7]) |=> keypad_event_flags[7])
    else $error("high level on line 7 not flagged");

  // a set flag holds until software clears that bit
  flag0_held_a : assert property (
    (keypad_event_flags[0] && !(wr_clear && bus_req.wdata[0])) |=> keypad_event_flags[0])
    else $error("flag 0 dropped without clear");

  flag1_held_a : assert property (
    (keypad_event_flags[1] && !(wr_clear && bus_req.wdata[1])) |=> keypad_event_flags[1])
    else $error("flag 1 dropped without clear");

  flag2_held_a : assert property (
    (keypad_event_flags[2] && !(wr_clear && bus_req.wdata[2])) |=> keypad_event_flags[2])
    else $error("flag 2 dropped without clear");

  flag3_held_a : assert property (
    (keypad_event_flags[3] && !(wr_clear && bus_req.wdata[3])) |=> keypad_event_flags[3])
    else $error("flag 3 dropped without clear");

  flag4_held_a : assert property (
    (keypad_event_flags[4] && !(wr_clear && bus_req.wdata[4])) |=> keypad_event_flags[4])
    else $error("flag 4 dropped without clear");

  flag5_held_a : assert property (
    (keypad_event_flags[5] && !(wr_clear && bus_req.wdata[5])) |=> keypad_event_flags[5])
    else $error("flag 5 dropped without clear");

  flag6_held_a : assert property (
    (keypad_event_flags[6] && !(wr_clear && bus_req.wdata[6])) |=> keypad_event_flags[6])
    else $error("flag 6 dropped without clear");

  flag7_held_a : assert property (
    (keypad_event_flags[7] && !(wr_clear && bus_req.wdata[7])) |=> keypad_event_flags[7])
    else $error("flag 7 dropped without clear");

  // no flag rises without a level match
  flag0_quiet_a : assert property (
    (!keypad_event_flags[0] && !line_match[0]) |=> !keypad_event_flags[0])
    else $error("flag 0 set without a match");

  flag1_quiet_a : assert property (
    (!keypad_event_flags[1] && !line_match[1]) |=> !keypad_event_flags[1])
    else $error("flag 1 set without a match");

  flag2_quiet_a : assert property (
    (!keypad_event_flags[2] && !line_match[2]) |=> !keypad_event_flags[2])
    else $error("flag 2 set without a match");

  flag3_quiet_a : assert property (
    (!keypad_event_flags[3] && !line_match[3]) |=> !keypad_event_flags[3])
    else $error("flag 3 set without a match");

  flag4_quiet_a : assert property (
    (!keypad_event_flags[4] && !line_match[4]) |=> !keypad_event_flags[4])
    else $error("flag 4 set without a match");

  flag5_quiet_a : assert property (
    (!keypad_event_flags[5] && !line_match[5]) |=> !keypad_event_flags[5])
    else $error("flag 5 set without a match");

  flag6_quiet_a : assert property (
    (!keypad_event_flags[6] && !line_match[6]) |=> !keypad_event_flags[6])
    else $error("flag 6 set without a match");

  flag7_quiet_a : assert property (
    (!keypad_event_flags[7] && !line_match[7]) |=> !keypad_event_flags[7])
    else $error("flag 7 set without a match");

  // any single enabled flag is enough for the request
  line0_irq_a : assert property (
    (keypad_event_flags[0] && keypad_line_enable[0]) |=> irq)
    else $error("enabled flag 0 did not raise interrupt");

  line1_irq_a : assert property (
    (keypad_event_flags[1] && keypad_line_enable[1]) |=> irq)
    else $error("enabled flag 1 did not raise interrupt");

  line2_irq_a : assert property (
    (keypad_event_flags[2] && keypad_line_enable[2]) |=> irq)
    else $error("enabled flag 2 did not raise interrupt");

  line3_irq_a : assert property (
    (keypad_event_flags[3] && keypad_line_enable[3]) |=> irq)
    else $error("enabled flag 3 did not raise interrupt");

  line4_irq_a : assert property (
    (keypad_event_flags[4] && keypad_line_enable[4]) |=> irq)
    else $error("enabled flag 4 did not raise interrupt");

  line5_irq_a : assert property (
    (keypad_event_flags[5] && keypad_line_enable[5]) |=> irq)
    else $error("enabled flag 5 did not raise interrupt");

  line6_irq_a : assert property (
    (keypad_event_flags[6] && keypad_line_enable[6]) |=> irq)
    else $error("enabled flag 6 did not raise interrupt");

  line7_irq_a : assert property (
    (keypad_event_flags[7] && keypad_line_enable[7]) |=> irq)
    else $error("enabled flag 7 did not raise interrupt");

  // pins reach the flag logic two edges late; a reset in between voids the check
  sync_delay_a : assert property (
    ($past(rst_n, 2) && $past(rst_n)) |-> pin_sync == $past(port_pins, 2))
    else $error("pin synchroniser delay wrong");

  level_write_a : assert property (
    wr_level |=> keypad_level_select == $past(bus_req.wdata))
    else $error("level select write not applied");

  level_hold_a : assert property (
    !wr_level |=> $stable(keypad_level_select))
    else $error("level select changed without a write");

  enable_hold_a : assert property (
    !wr_en |=> $stable(keypad_line_enable))
    else $error("line enable changed without a write");

  flags_ro_a : assert property (
    (bus_req.wr && hit_flags) |=>
    keypad_event_flags == ($past(keypad_event_flags) | $past(line_match)))
    else $error("write to flag register changed it");

  sequence s_read_enable;
    bus_req.rd && hit_en;
  endsequence

  sequence s_read_flags;
    bus_req.rd && hit_flags;
  endsequence

  read_enable_a : assert property (
    s_read_enable |=> rd_data == $past(keypad_line_enable))
    else $error("line enable readback wrong");

  read_flags_a : assert property (
    s_read_flags |=> rd_data == $past(keypad_event_flags))
    else $error("event flag readback wrong");

  read_clear_zero_a : assert property (
    (bus_req.rd && bus_req.addr == KPW_OFF_FLAG_CLEAR) |=> rd_data == 8'h00)
    else $error("clear register read back nonzero");

  read_idle_a : assert property (
    !bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");

  // a line that still matches keeps its flag through a clear
  set_wins_a : assert property (
    wr_clear |=> (keypad_event_flags & $past(line_match)) == $past(line_match))
    else $error("clear beat a live level match");

endmodule // kpw_keypad_wakeup
`default_nettype wire

// ---- tb/kpw_keypad_model.sv ----
// keypad matrix model driving the port lines
`timescale 1ns/1ps
`default_nettype none
module kpw_keypad_model (
  input  wire logic       clk,
  input  wire logic [7:0] keys,
  output var  logic [7:0] port_pins
);
  // contacts settle one clock after the bench moves a key
  always_ff @(posedge clk) port_pins <= keys;
endmodule // kpw_keypad_model
`default_nettype wire

// ---- tb/kpw_keypad_wakeup_tb.sv ----
// self-checking bench for the keypad wakeup block
`timescale 1ns/1ps
`default_nettype none
module kpw_keypad_wakeup_tb;
  import kpw_pkg::*;
  logic         clk = 0, rst_n = 1, irq;
  kpw_bus_req_t bus = '0;
  logic [7:0]   rd_data, pins, mode, keys = 8'h00, s, e, p;
  logic [31:0]  rs = 33352;
  int           err_count = 0, check_count = 0;
  kpw_keypad_wakeup i_kpw_keypad_wakeup (.clk(clk), .rst_n(rst_n), .bus_req(bus),
    .rd_data(rd_data), .port_pins(pins), .line_kbd_mode(mode), .irq(irq));
  kpw_keypad_model i_kpw_keypad_model (.clk(clk), .keys(keys), .port_pins(pins));
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic logic [7:0] hit(input logic [7:0] pv, sv);
    return pv ~^ sv;
  endfunction
  task automatic chk(input string n, input logic [7:0] ex, got);
    check_count++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, ex, input string n);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(n, ex, rd_data);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    // a real falling edge, so the asynchronous reset acts before the first clock
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(KPW_OFF_LEVEL_SELECT, 8'h00, "lsel_rst");
    rd(KPW_OFF_LINE_ENABLE, 8'h00, "len_rst");
    for (int i = 0; i < 24; i++) begin
      s = (i < 2) ? {8{i[0]}} : rnd();
      e = (i < 4) ? {8{i[1]}} : rnd();
      p = rnd();
      wr(KPW_OFF_LEVEL_SELECT, s);
      wr(KPW_OFF_LINE_ENABLE, e);
      // park pins off level first, else set would win over the clear
      keys <= ~s;
      repeat (5) @(posedge clk);
      wr(KPW_OFF_FLAG_CLEAR, 8'hFF);
      rd(KPW_OFF_EVENT_FLAGS, 8'h00, "flags_clr");
      chk("irq_clr", 8'h00, {7'h00, irq});
      keys <= p;
      repeat (5) @(posedge clk);
      rd(KPW_OFF_EVENT_FLAGS, hit(p, s), "flags");
      chk("irq", {7'h00, |(hit(p, s) & e)}, {7'h00, irq});
      chk("mode", e, mode);
      // flag register ignores writes; a clear while pins still match loses
      wr(KPW_OFF_EVENT_FLAGS, 8'hFF);
      wr(KPW_OFF_FLAG_CLEAR, 8'hFF);
      rd(KPW_OFF_EVENT_FLAGS, hit(p, s), "flags_keep");
      rd(KPW_OFF_LEVEL_SELECT, s, "lsel");
      rd(KPW_OFF_LINE_ENABLE, e, "len");
      rd(KPW_OFF_FLAG_CLEAR, 8'h00, "clr_read");
      rd(8'h00, 8'h00, "unmapped");
    end
    // reset in mid-run must drop both registers again
    wr(KPW_OFF_LEVEL_SELECT, 8'hA5);
    wr(KPW_OFF_LINE_ENABLE, 8'h5A);
    rst_n <= 1'b0;
    #1 chk("mode_rst", 8'h00, mode);
    chk("irq_rst", 8'h00, {7'h00, irq});
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(KPW_OFF_LEVEL_SELECT, 8'h00, "lsel_rst2");
    rd(KPW_OFF_LINE_ENABLE, 8'h00, "len_rst2");
    complete_run();
  end
endmodule // kpw_keypad_wakeup_tb
`default_nettype wire
